// >>> verilog/fcnt_cfg.svh
/*
  Constants of the clock-ratio frequency counter: register addresses,
  field positions, reset values, mode codes and timing counts.
  Assumes inclusion by bare name from the package; the design module uses its macros without including it.
*/
// What this block does
// - Only mode code 000 disables the counter
// - Disabling stops counting at once, restartable immediately
// - Nonzero mode enables counter, idle awaiting trigger
// - Writing active bit 1 triggers, clears complete
// - Complete flag writable; writing 1 raises request
// - Complete flag is level request until cleared
// - After sync delay, first gate rise starts counting
// - Gate rise after programmed cycles stops counting
// - Active clears; complete sets few cycles later
// - After completion counters stop, count held
// - 23-bit result readable as word at 0x4008
// - Reading while active returns live count
// - Retrigger while active zeroes count, rewaits edge
// - Window = (2 + code[0]) shifted by code[5:1]
// - Length code above 43 forces one-cycle window
// - Source select 0 LC, 1 divider; off when disabled
// - Mode code selects gate clock source
// - Control bits 4:3 read zero, ignore writes
// - Crystal clock usable as gate source
`ifndef FCNT_CFG_SVH
`define FCNT_CFG_SVH

`define COUNTER_CONTROL_ADDR 8'h9B
`define FC_LEN_ADDR 8'h9D
`define FC_TALLY_ADDR 16'h4008
`define COUNTER_CONTROL_RST 8'h00
`define FC_LEN_RST 6'h00
`define MEASURE_COMPLETE_BIT 7
`define FC_ACTIVE_BIT 6
`define FC_SEL_BIT 5
`define GATE_SOURCE_MODE_MSB 2
`define FC_LEN_MSB 5
`define GATE_SOURCE_MODE_OFF 3'h0
`define GATE_SOURCE_MODE_REF 3'h1
`define GATE_SOURCE_MODE_LPOSC 3'h2
`define GATE_SOURCE_MODE_SYS 3'h3
`define GATE_SOURCE_MODE_XO 3'h4
`define GATE_SOURCE_MODE_SLEEP 3'h6
`define FC_LEN_MAX 6'h2B
`define FC_SYNC_CYC 3'h3
`define MEASURE_COMPLETE_DLY 2

`endif

// >>> verilog/fcnt_pkg.sv
/*
  Types of the clock-ratio frequency counter.
  Assumes fcnt_cfg.svh sits on the include path.
*/
`default_nettype none
package fcnt_pkg;
  `include "fcnt_cfg.svh"
  typedef enum logic [2:0] {
    ST_OFF,
    ST_IDLE,
    ST_SYNC,
    ST_WAIT,
    ST_COUNT
  } fc_state_e;
endpackage
`default_nettype wire

// >>> verilog/clock_ratio_frequency_counter.sv
/*
  Frequency-ratio counter: a gate clock defines a window in which a
  high-speed clock is tallied; SFR control, XREG readout.
  Assumes all source clocks are asynchronous pins sampled on sys_clk_i,
  and that counted clocks are slower than half of sys_clk_i.
*/
`default_nettype none
module clock_ratio_frequency_counter
  import fcnt_pkg::*;
#(
  parameter int TALLY_W = 23,
  parameter int LEN_W = 6
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // SFR port
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_wdata_i,
  output logic [7:0] sfr_rdata_o,
  // XREG read port
  input wire logic [15:0] xreg_addr_i,
  input wire logic xreg_rd_i,
  output logic [31:0] xreg_rdata_o,
  // Gate clock sources
  input wire logic gate_ref_i,
  input wire logic lposc_clk_i,
  input wire logic crystal_clock_i,
  input wire logic sleep_timer_i,
  // Counted clock sources
  input wire logic lc_oscillator_i,
  input wire logic divider_clk_i,
  // Source enables and status
  output logic lc_osc_enable_o,
  output logic divider_enable_o,
  output logic measure_active_o,
  output logic measure_complete_o
);

  // Window length in gate cycles; codes above the limit give one cycle
  function automatic logic [TALLY_W-1:0] window_len(input logic [LEN_W-1:0] code);
    logic [TALLY_W-1:0] base;
    base = code[0] ? TALLY_W'(3) : TALLY_W'(2);
    if (code > `FC_LEN_MAX) begin
      window_len = TALLY_W'(1);
    end else begin
      window_len = base << code[LEN_W-1:1];
    end
  endfunction

  // Register state
  logic [2:0] mode_ff;
  logic sel_ff;
  logic [LEN_W-1:0] code_ff;
  logic done_ff;
  fc_state_e state_ff;
  logic [2:0] delay_ff;
  logic [TALLY_W-1:0] remain_ff;
  logic [TALLY_W-1:0] tally_ff;
  logic [`MEASURE_COMPLETE_DLY-1:0] done_pipe_ff;
  logic [5:0] sync1_ff;
  logic [5:0] sync2_ff;
  logic [5:0] prev_ff;

  // Decoded strobes
  logic ctrl_wr;
  logic len_wr;
  logic [2:0] wr_mode;
  logic disable_req;
  logic trig;
  logic [5:0] rise;
  logic gate_rise;
  logic count_rise;
  logic finish;
  logic active;

  assign ctrl_wr = sfr_wr_i && (sfr_addr_i == `COUNTER_CONTROL_ADDR);
  assign len_wr = sfr_wr_i && (sfr_addr_i == `FC_LEN_ADDR);
  assign wr_mode = sfr_wdata_i[`GATE_SOURCE_MODE_MSB:0];
  assign disable_req = ctrl_wr && (wr_mode == `GATE_SOURCE_MODE_OFF);
  // Trigger only counts when the same write leaves the block enabled
  assign trig = ctrl_wr && sfr_wdata_i[`FC_ACTIVE_BIT] && (wr_mode != `GATE_SOURCE_MODE_OFF);
  assign active = (state_ff == ST_SYNC) || (state_ff == ST_WAIT) || (state_ff == ST_COUNT);

  // Two-flop synchronisers; edge detection reads only the second stage
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sync1_ff <= 6'h00;
      sync2_ff <= 6'h00;
      prev_ff <= 6'h00;
    end else begin
      sync1_ff <= {divider_clk_i, lc_oscillator_i, sleep_timer_i,
                   crystal_clock_i, lposc_clk_i, gate_ref_i};
      sync2_ff <= sync1_ff;
      prev_ff <= sync2_ff;
    end
  end

  assign rise = sync2_ff & ~prev_ff;

  // Gate clock select; system clock mode sees an edge every cycle
  always_comb begin
    case (mode_ff)
      `GATE_SOURCE_MODE_REF: gate_rise = rise[0];
      `GATE_SOURCE_MODE_LPOSC: gate_rise = rise[1];
      `GATE_SOURCE_MODE_SYS: gate_rise = 1'b1;
      `GATE_SOURCE_MODE_XO: gate_rise = rise[2];
      `GATE_SOURCE_MODE_SLEEP: gate_rise = rise[3];
      default: gate_rise = 1'b0;
    endcase
  end

  // Counted clock select
  assign count_rise = sel_ff ? rise[5] : rise[4];
  assign finish = (state_ff == ST_COUNT) && gate_rise && (remain_ff == TALLY_W'(1));

  // Control fields; bits 4:3 are not stored
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mode_ff <= `GATE_SOURCE_MODE_OFF;
      sel_ff <= 1'b0;
    end else if (ctrl_wr) begin
      mode_ff <= wr_mode;
      sel_ff <= sfr_wdata_i[`FC_SEL_BIT];
    end
  end

  // Length code register
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      code_ff <= `FC_LEN_RST;
    end else if (len_wr) begin
      code_ff <= sfr_wdata_i[`FC_LEN_MSB:0];
    end
  end

  // Measurement sequence: off, idle, sync delay, wait edge, count
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_ff <= ST_OFF;
      delay_ff <= 3'h0;
      remain_ff <= '0;
    end else if (disable_req) begin
      state_ff <= ST_OFF;
    end else if (trig) begin
      state_ff <= ST_SYNC;
      delay_ff <= 3'h0;
    end else begin
      case (state_ff)
        ST_OFF: begin
          if (ctrl_wr) begin
            state_ff <= ST_IDLE;
          end
        end
        ST_IDLE: begin
          state_ff <= ST_IDLE;
        end
        ST_SYNC: begin
          // Matches the settling time of a real cross-domain trigger
          if (delay_ff == `FC_SYNC_CYC - 3'h1) begin
            state_ff <= ST_WAIT;
          end else begin
            delay_ff <= delay_ff + 3'h1;
          end
        end
        ST_WAIT: begin
          if (gate_rise) begin
            state_ff <= ST_COUNT;
            remain_ff <= window_len(code_ff);
          end
        end
        ST_COUNT: begin
          if (finish) begin
            state_ff <= ST_IDLE;
          end else if (gate_rise) begin
            remain_ff <= remain_ff - TALLY_W'(1);
          end
        end
        default: begin
          state_ff <= ST_OFF;
        end
      endcase
    end
  end

  // Main tally; cleared on trigger or disable, held once idle
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tally_ff <= '0;
    end else if (trig || disable_req) begin
      tally_ff <= '0;
    end else if ((state_ff == ST_COUNT) && count_rise) begin
      tally_ff <= tally_ff + TALLY_W'(1);
    end
  end

  // Delay from end of window to completion; flushed by restart
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      done_pipe_ff <= '0;
    end else if (trig || disable_req) begin
      done_pipe_ff <= '0;
    end else begin
      done_pipe_ff <= {done_pipe_ff[`MEASURE_COMPLETE_DLY-2:0], finish};
    end
  end

  // Completion flag; hardware set wins over a same-cycle write
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      done_ff <= 1'b0;
    end else if (done_pipe_ff[`MEASURE_COMPLETE_DLY-1]) begin
      done_ff <= 1'b1;
    end else if (ctrl_wr) begin
      done_ff <= sfr_wdata_i[`FC_ACTIVE_BIT] ? 1'b0 : sfr_wdata_i[`MEASURE_COMPLETE_BIT];
    end
  end

  // Status outputs, all from flip-flops
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      lc_osc_enable_o <= 1'b0;
      divider_enable_o <= 1'b0;
      measure_active_o <= 1'b0;
      measure_complete_o <= 1'b0;
    end else begin
      lc_osc_enable_o <= (mode_ff != `GATE_SOURCE_MODE_OFF) && !sel_ff;
      divider_enable_o <= (mode_ff != `GATE_SOURCE_MODE_OFF) && sel_ff;
      measure_active_o <= active;
      measure_complete_o <= done_ff;
    end
  end

  // SFR read data, one cycle after the strobe; unmapped reads zero
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sfr_rdata_o <= 8'h00;
    end else if (sfr_rd_i) begin
      case (sfr_addr_i)
        `COUNTER_CONTROL_ADDR: sfr_rdata_o <= {done_ff, active, sel_ff, 2'h0, mode_ff};
        `FC_LEN_ADDR: sfr_rdata_o <= {2'h0, code_ff};
        default: sfr_rdata_o <= 8'h00;
      endcase
    end
  end

  // XREG readout shows the live tally while counting
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      xreg_rdata_o <= 32'h00000000;
    end else if (xreg_rd_i) begin
      if (xreg_addr_i == `FC_TALLY_ADDR) begin
        xreg_rdata_o <= {{(32-TALLY_W){1'b0}}, tally_ff};
      end else begin
        xreg_rdata_o <= 32'h00000000;
      end
    end
  end

endmodule
`default_nettype wire

// >>> testbench/fcnt_src_model.sv
/* Oscillator stand-ins for the gate and counted clock sources.
   Assumes the counter gates the counted sources by its enables. */
`default_nettype none
module fcnt_src_model (
  // Enables from the counter
  input wire logic lc_osc_enable_i,
  input wire logic divider_enable_i,
  // Gate sources
  output logic gate_ref_o,
  output logic lposc_clk_o,
  output logic crystal_clock_o,
  output logic sleep_timer_o,
  // Counted sources
  output logic lc_oscillator_o,
  output logic divider_clk_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic lc_run = 1'b0;
  logic div_run = 1'b0;
  // Edges on falling system edges only, so sampling never races
  initial begin
    gate_ref_o = 1'b0;
    lposc_clk_o = 1'b0;
    crystal_clock_o = 1'b0;
    sleep_timer_o = 1'b0;
  end
  always #960 gate_ref_o = ~gate_ref_o;
  always #480 lposc_clk_o = ~lposc_clk_o;
  always #720 crystal_clock_o = ~crystal_clock_o;
  always #1440 sleep_timer_o = ~sleep_timer_o;
  always #80 lc_run = ~lc_run;
  always #120 div_run = ~div_run;
  // A disabled source stays low, as the real oscillator would
  assign lc_oscillator_o = lc_run & lc_osc_enable_i;
  assign divider_clk_o = div_run & divider_enable_i;
endmodule
`default_nettype wire

// >>> testbench/clock_ratio_frequency_counter_props.sv
/* Port checker for the frequency counter.
   Assumes it is bound onto the counter. */
`default_nettype none
module fcnt_checker
  import fcnt_pkg::*;
#(parameter int TALLY_W = 23, parameter int LEN_W = 6) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // Register port
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic [7:0] sfr_rdata_o,
  // Status
  input wire logic lc_osc_enable_o,
  input wire logic divider_enable_o,
  input wire logic measure_active_o,
  input wire logic measure_complete_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  // Control writes, decoded once
  wire logic cw = sfr_wr_i && sfr_addr_i == 8'h9B;
  wire logic trig = cw && sfr_wdata_i[6] && sfr_wdata_i[2:0] != 3'h0;
  wire logic off = cw && sfr_wdata_i[2:0] == 3'h0;
  // Window close not caused by software
  sequence win_end;
    $fell(measure_active_o) && !$past(cw) && !$past(cw, 2);
  endsequence
  sequence soft_set;
    cw && sfr_wdata_i[7] && !sfr_wdata_i[6];
  endsequence
  trig_busy_a: assert property (trig |-> ##2 measure_active_o) else $error("no busy");
  trig_clr_a: assert property (trig |-> ##2 !measure_complete_o) else $error("done kept");
  off_stop_a: assert property (off |-> ##2 !measure_active_o && !lc_osc_enable_o &&
    !divider_enable_o) else $error("not stopped");
  one_src_a: assert property (!(lc_osc_enable_o && divider_enable_o)) else $error("two srcs");
  done_rise_a: assert property (win_end |-> ##[1:4] measure_complete_o) else $error("no done");
  done_hold_a: assert property ($fell(measure_complete_o) |-> $past(cw, 2))
    else $error("done lost");
  soft_raise_a: assert property (soft_set |-> ##2 measure_complete_o) else $error("no raise");
  rsv_zero_a: assert property (sfr_rdata_o[4:3] == 2'b00) else $error("bits 4:3 set");
endmodule
bind clock_ratio_frequency_counter fcnt_checker #(.TALLY_W(TALLY_W), .LEN_W(LEN_W)) chk_i (
  .sys_clk_i, .sys_rst_i, .sfr_addr_i, .sfr_wr_i, .sfr_wdata_i, .sfr_rdata_o,
  .lc_osc_enable_o, .divider_enable_o, .measure_active_o, .measure_complete_o);
`default_nettype wire

// >>> testbench/tb_clock_ratio_frequency_counter.sv
/* Self-checking bench for the frequency counter.
   Assumes the oscillator model and the bound checker. */
`default_nettype none
module tb_clock_ratio_frequency_counter
  import fcnt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [31:0] v; logic [31:0] t; bit x;} note_s;
  note_s q[$];
  note_s n;
  logic sys_clk_i = 1'b0, sys_rst_i = 1'b1, sfr_wr_i = 1'b0, sfr_rd_i = 1'b0, xreg_rd_i = 1'b0;
  logic [7:0] sfr_addr_i = 8'h00, sfr_wdata_i = 8'h00;
  logic [15:0] xreg_addr_i = 16'h0000;
  logic [31:0] seen, r;
  logic [1:0] pend = 2'b00;
  logic ok;
  wire logic [7:0] sfr_rdata_o;
  wire logic [31:0] xreg_rdata_o;
  wire logic gate_ref_i, lposc_clk_i, crystal_clock_i, sleep_timer_i;
  wire logic lc_oscillator_i, divider_clk_i, lc_osc_enable_o, divider_enable_o;
  wire logic measure_active_o, measure_complete_o;
  int fails = 0, cmp_count = 0, seed = 30118, i, k;
  logic [2:0] modes [5] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h6};
  int gp [5] = '{1920, 960, 40, 1440, 2880};
  always #20 sys_clk_i = ~sys_clk_i;
  clock_ratio_frequency_counter clock_ratio_frequency_counter_i (.sys_clk_i, .sys_rst_i,
    .sfr_addr_i, .sfr_wr_i, .sfr_rd_i, .sfr_wdata_i, .sfr_rdata_o, .xreg_addr_i, .xreg_rd_i,
    .xreg_rdata_o, .gate_ref_i, .lposc_clk_i, .crystal_clock_i, .sleep_timer_i,
    .lc_oscillator_i, .divider_clk_i, .lc_osc_enable_o, .divider_enable_o,
    .measure_active_o, .measure_complete_o);
  fcnt_src_model fcnt_src_model_i (.lc_osc_enable_i(lc_osc_enable_o),
    .divider_enable_i(divider_enable_o), .gate_ref_o(gate_ref_i), .lposc_clk_o(lposc_clk_i),
    .crystal_clock_o(crystal_clock_i), .sleep_timer_o(sleep_timer_i),
    .lc_oscillator_o(lc_oscillator_i), .divider_clk_o(divider_clk_i));
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    sfr_addr_i <= a;
    sfr_wdata_i <= d;
    sfr_wr_i <= 1'b1;
    @(posedge sys_clk_i);
    sfr_wr_i <= 1'b0;
  endtask
  // Reads note their expectation; tolerance covers edge quantisation
  task automatic rd(input bit x, input logic [15:0] a, input logic [31:0] v, input int t);
    q.push_back('{v, 32'(t), x});
    @(posedge sys_clk_i);
    sfr_addr_i <= a[7:0];
    xreg_addr_i <= a;
    sfr_rd_i <= !x;
    xreg_rd_i <= x;
    @(posedge sys_clk_i);
    sfr_rd_i <= 1'b0;
    xreg_rd_i <= 1'b0;
  endtask
  task automatic meas(input logic [2:0] m, input logic s, input logic [5:0] c, input int pg);
    int nw;
    nw = c > 6'd43 ? 1 : (2 + c[0]) << c[5:1];
    wr(8'h9D, {2'b00, c});
    wr(8'h9B, {2'b01, s, 2'b00, m});
    for (i = 0; i < 8000 && measure_complete_o !== 1'b1; i++) @(posedge sys_clk_i);
    if (i == 8000) fails++;
    rd(1'b1, 16'h4008, nw * pg / (s ? 240 : 160), 2);
    rd(1'b0, 16'h009B, {2'b10, s, 2'b00, m}, 0);
    rd(1'b1, 16'h4008, nw * pg / (s ? 240 : 160), 2);
    wr(8'h9B, {2'b00, s, 2'b00, m});
  endtask
  // Answer lands one edge after the strobe
  always @(posedge sys_clk_i) pend <= {xreg_rd_i, sfr_rd_i};
  always @(negedge sys_clk_i) begin
    if (pend != 2'b00) begin
      n = q.pop_front();
      seen = n.x ? xreg_rdata_o : {24'h0, sfr_rdata_o};
      ok = seen + n.t >= n.v && seen <= n.v + n.t;
      cmp_count++;
      if (ok !== 1'b1) begin
        fails++;
        $display("mismatch %s exp %h seen %h", n.x ? "tally" : "sfr", n.v, seen);
      end
    end
  end
  task automatic final_report;
    if (fails == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Ceiling well above the slowest window sequence
  initial begin
    #(40 * 90000);
    fails++;
    final_report;
  end
  initial begin
    repeat (3) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    rd(1'b0, 16'h009B, 32'h0, 0);
    rd(1'b0, 16'h009D, 32'h0, 0);
    rd(1'b1, 16'h4008, 32'h0, 0);
    rd(1'b0, 16'h009C, 32'h0, 0);
    wr(8'h9B, 8'h18);
    rd(1'b0, 16'h009B, 32'h0, 0);
    for (k = 0; k < 5; k++) begin
      r = $random(seed);
      meas(modes[k], modes[k][2], 6'd4 + {3'b000, r[2:0]}, gp[k]);
    end
    r = $random(seed);
    meas(3'h3, 1'b0, 6'd44 + {2'b00, r[3:0]}, 40);
    // Retrigger mid-window must restart from zero; long window first
    wr(8'h9D, 8'h0B);
    wr(8'h9B, 8'h43);
    repeat (40) @(posedge sys_clk_i);
    rd(1'b1, 16'h4008, 32'd8, 3);
    meas(3'h3, 1'b0, 6'd11, 40);
    // Disable mid-window, check control and tally read zero, then restart
    wr(8'h9B, 8'h43);
    repeat (20) @(posedge sys_clk_i);
    wr(8'h9B, 8'h00);
    rd(1'b0, 16'h009B, 32'h0, 0);
    rd(1'b1, 16'h4008, 32'h0, 0);
    meas(3'h3, 1'b0, 6'd11, 40);
    wr(8'h9B, 8'h83);
    rd(1'b0, 16'h009B, 32'h83, 0);
    wr(8'h9B, 8'h03);
    rd(1'b0, 16'h009B, 32'h03, 0);
    final_report;
  end
endmodule
`default_nettype wire
